// File: bench/engine_model.sv
`timescale 1ns/1ns
module engine_model (
  // clock
  input wire logic clk,
  // actuator commands
  input wire logic starterOn,
  input wire logic fuelRun,
  // scenario control: engine fires when cranked
  input wire logic willStart,
  // measured speed
  output logic [15:0] engineRpm
);
  // crank speed stays below any sane start threshold
  localparam logic [15:0] CrankRpm = 16'h0096;
  localparam logic [15:0] RunRpm = 16'h05DC;
  initial engineRpm = 16'h0000;
  // slow spin-up so the threshold is crossed only after a few cycles
  always @(posedge clk)
  begin
    if (starterOn && willStart && engineRpm < RunRpm)
    begin
      engineRpm <= engineRpm + 16'h0064;
    end
    else if (starterOn && !willStart)
    begin
      engineRpm <= CrankRpm;
    end
    else if (!fuelRun && !starterOn)
    begin
      // coast down once fuel is cut
      engineRpm <= (engineRpm > 16'h00C8) ? engineRpm - 16'h00C8 : 16'h0000;
    end
  end
endmodule : engine_model

// File: bench/genset_seq_sva.sv
`timescale 1ns/1ns
module genset_seq_sva (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched pins
  input wire logic signed [7:0] inverterTempC,
  input wire genset_pkg::mode_t statusMode,
  input wire logic [6:0] barPct,
  input wire logic startFailed,
  input wire logic faultActive,
  input wire logic powerDown,
  input wire logic glowOn,
  input wire logic starterOn,
  input wire logic fuelRun,
  input wire logic inverterOn,
  input wire logic speedMax
);
  import genset_pkg::*;
  // one domain, so clock and disable are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // heater switched on
  sequence s_glow_start;
    $rose(glowOn);
  endsequence
  // heater kept on; a phase shorter than eight cycles is a broken timer
  sequence s_glow_hold;
    glowOn [*8];
  endsequence
  a_preheat_min_hold: assert property (s_glow_start |-> s_glow_hold)
    else $error("preheat ended early");
  a_glow_decode: assert property (glowOn == (statusMode == MODE_PREHEAT))
    else $error("glow heater out of step with mode");
  a_starter_decode: assert property (starterOn == (statusMode == MODE_STARTING))
    else $error("starter out of step with mode");
  a_fail_after_crank: assert property ($rose(startFailed) |-> $past(statusMode) == MODE_STARTING)
    else $error("start failure without cranking");
  a_override_no_fault: assert property (statusMode == MODE_OVERRIDE |-> !faultActive)
    else $error("fault flagged in override");
  a_bar_idle_zero: assert property (statusMode != MODE_RUNNING |-> barPct == 7'h00)
    else $error("bar graph outside running");
  a_inverter_trip: assert property (inverterTempC >= INV_TRIP_C |=> !inverterOn)
    else $error("inverter on while hot");
  a_clutch_speed: assert property (speedMax |-> statusMode inside {MODE_OVERRIDE, MODE_RUNNING})
    else $error("max speed while not running");
  a_stop_no_fuel: assert property (statusMode == MODE_STOPPING |-> !fuelRun)
    else $error("fuel on while stopping");
  a_off_power_down: assert property (powerDown == (statusMode == MODE_OFF))
    else $error("power down out of step with mode");
  a_fault_stops_set: assert property (faultActive |-> statusMode == MODE_STOPPING)
    else $error("fault flagged outside a stop");
endmodule : genset_seq_sva

bind genset_start_mode_sequencer genset_seq_sva genset_seq_sva_i (.clk, .resetn, .inverterTempC, .statusMode,
  .barPct, .startFailed, .faultActive, .powerDown, .glowOn, .starterOn, .fuelRun, .inverterOn, .speedMax);

// File: bench/genset_start_mode_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin numErrors++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module genset_start_mode_sequencer_tb;
  import genset_pkg::*;
  // short second keeps phases to a few hundred cycles
  localparam int Sc = 20;
  localparam logic [2:0] Pages = 3'h2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] btns = 5'h00; // indexed by the IN_ constants
  logic signed [7:0] headT = 8'sh14;
  logic signed [7:0] invT = 8'sh28;
  logic [6:0] load = 7'h00;
  logic faultIn = 1'b0;
  logic dynEn = 1'b0;
  logic [15:0] baseH = 16'h0000;
  logic [15:0] extraH = 16'h0000;
  logic willStart = 1'b0;
  logic [31:0] seed = 32'hE2D376CF;
  int numErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  int btnList[3] = '{IN_UP, IN_DOWN, IN_START};
  mode_t statusMode;
  screen_t screenSel;
  logic [2:0] inverterPage;
  logic [6:0] barPct;
  logic [15:0] serviceIntervalH;
  logic [15:0] engineRpm;
  logic startFailed, faultActive, powerDown, glowOn, starterOn, fuelRun, inverterOn, speedMax;

  genset_start_mode_sequencer #(.SecCycles(Sc), .NumInvPages(Pages)) genset_start_mode_sequencer_i (
    .clk(clk), .resetn(resetn), .btnOnOff(btns[IN_ONOFF]), .btnStartStop(btns[IN_START]), .btnUp(btns[IN_UP]),
    .btnDown(btns[IN_DOWN]), .clutchEngaged(btns[IN_CLUTCH]), .headTempC(headT), .inverterTempC(invT),
    .engineRpm(engineRpm), .loadPct(load), .faultIn(faultIn), .startRpm(16'h0190), .crankLimitSec(6'h03),
    .dynamicHoursEn(dynEn), .serviceBaseH(baseH), .serviceExtraH(extraH), .statusMode(statusMode),
    .screenSel(screenSel), .inverterPage(inverterPage), .barPct(barPct), .serviceIntervalH(serviceIntervalH),
    .startFailed(startFailed), .faultActive(faultActive), .powerDown(powerDown), .glowOn(glowOn),
    .starterOn(starterOn), .fuelRun(fuelRun), .inverterOn(inverterOn), .speedMax(speedMax));
  engine_model engine_model_i (.clk(clk), .starterOn(starterOn), .fuelRun(fuelRun), .willStart(willStart),
    .engineRpm(engineRpm));

  // free-running clock, 100 ns period
  initial forever #50 clk = ~clk;
  // hang guard, well above the planned run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      numErrors++;
      close_out();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // reference service interval from the extension limits
  function automatic logic [15:0] svc(input logic en, input logic [15:0] b, input logic [15:0] x);
    int cap;
    int sum;
    cap = int'(b) * 30 / 100;
    if (cap > 200) cap = 200;
    sum = en ? int'(b) + ((int'(x) < cap) ? int'(x) : cap) : int'(b);
    return (sum > 65535) ? 16'hFFFF : sum[15:0];
  endfunction : svc
  // wait n edges, end where outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick
  // one press; a long hold must still give one event
  task automatic press(input int b, input int hold);
    @(posedge clk);
    btns[b] <= 1'b1;
    repeat (hold) @(posedge clk);
    btns[b] <= 1'b0;
    tick(4);
  endtask : press
  task automatic wait_mode(input mode_t m, input int lim);
    int n;
    n = 0;
    while (statusMode !== m && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(statusMode, m)
  endtask : wait_mode
  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK(statusMode, MODE_STANDBY)
    tick(Sc * 4);
    `CHK(screenSel, SCR_SPLASH)
    tick(Sc * 2);
    `CHK(screenSel, SCR_DEFAULT)
    press(IN_UP, 10);
    `CHK(screenSel, SCR_SERVICE)
    press(IN_DOWN, 2);
    `CHK(screenSel, SCR_DEFAULT)
    // random service inputs, small bases reach the percentage cap
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      dynEn <= i[0];
      baseH <= seed[15:0] >> (4 * i);
      extraH <= {7'h00, seed[24:16]};
      tick(3);
      `CHK(serviceIntervalH, svc(dynEn, baseH, extraH))
    end
    // failed starts, cleared by each listed button in turn
    foreach (btnList[j])
    begin
      press(IN_START, 2);
      `CHK(glowOn, 1'b1)
      tick(Sc * 10 - 12);
      `CHK(statusMode, MODE_PREHEAT)
      wait_mode(MODE_STARTING, 20);
      `CHK(starterOn, 1'b1)
      wait_mode(MODE_START_FAIL, Sc * 3 + 10);
      tick(Sc * 2);
      `CHK(starterOn, 1'b0)
      `CHK(startFailed, 1'b1)
      press(btnList[j], 2);
      `CHK(statusMode, MODE_STANDBY)
    end
    // cold start that fires
    @(posedge clk);
    headT <= 8'shF8;
    willStart <= 1'b1;
    press(IN_START, 2);
    tick(Sc * 30);
    `CHK(statusMode, MODE_PREHEAT)
    wait_mode(MODE_STARTING, Sc * 10 + 10);
    wait_mode(MODE_OVERRIDE, 20);
    @(posedge clk);
    faultIn <= 1'b1;
    headT <= 8'sh14;
    tick(Sc * 8);
    `CHK(statusMode, MODE_OVERRIDE)
    @(posedge clk);
    faultIn <= 1'b0;
    wait_mode(MODE_RUNNING, Sc * 3);
    `CHK(fuelRun, 1'b1)
    for (int t = 74; t < 76; t++)
    begin
      @(posedge clk);
      invT <= t[7:0];
      tick(3);
      `CHK(inverterOn, (t < 75))
    end
    @(posedge clk);
    btns[IN_CLUTCH] <= 1'b1;
    tick(4);
    `CHK(speedMax, 1'b1)
    @(posedge clk);
    btns[IN_CLUTCH] <= 1'b0;
    tick(4);
    `CHK(speedMax, 1'b0)
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      load <= seed[6:0];
      tick(3);
      `CHK(barPct, ((load > LOAD_FULL_PCT) ? LOAD_FULL_PCT : load))
    end
    for (int i = 0; i <= Pages; i++)
    begin
      press(IN_UP, 2);
      `CHK(screenSel, ((i < Pages) ? SCR_INVERTER : SCR_DEFAULT))
      if (i < Pages) `CHK(inverterPage, i[2:0])
    end
    press(IN_START, 2);
    `CHK(statusMode, MODE_STOPPING)
    `CHK(fuelRun, 1'b0)
    wait_mode(MODE_STANDBY, 40);
    press(IN_ONOFF, 2);
    `CHK(powerDown, 1'b1)
    press(IN_ONOFF, 2);
    `CHK(statusMode, MODE_STANDBY)
    // a fault while running stops the set and stays flagged until stand-by
    press(IN_START, 2);
    wait_mode(MODE_RUNNING, Sc * 21 + 40);
    `CHK(faultActive, 1'b0)
    @(posedge clk);
    faultIn <= 1'b1;
    tick(2);
    `CHK(statusMode, MODE_STOPPING)
    `CHK(faultActive, 1'b1)
    @(posedge clk);
    faultIn <= 1'b0;
    wait_mode(MODE_STANDBY, 40);
    `CHK(faultActive, 1'b0)
    close_out();
  end
endmodule : genset_start_mode_sequencer_tb

// File: verilog/button_sync.sv
`timescale 1ns/1ns
module button_sync #(
  parameter int Width = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // raw pins, active high
  input wire logic [Width-1:0] rawIn,
  // synchronised levels and one-cycle press pulses
  output logic [Width-1:0] level,
  output logic [Width-1:0] press
);
  import genset_pkg::*;

  // whole state: two sync stages and the edge-detect stage
  typedef struct packed {
    logic [Width-1:0] meta;
    logic [Width-1:0] sync;
    logic [Width-1:0] last;
  } sync_state_t;

  sync_state_t st_ff; // registered state
  sync_state_t nxt_st; // next state

  // meta is read only by the sync stage
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = rawIn;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // one rising edge gives exactly one pulse
  assign level = st_ff.sync;
  assign press = st_ff.sync & ~st_ff.last;

endmodule : button_sync

// File: verilog/genset_pkg.sv
package genset_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 32'h64;
  localparam longint SEC_NS = 64'h3B9ACA00;
  // cycles in one second, derived from the clock period
  localparam int SEC_CYCLES = int'(SEC_NS / longint'(CLK_PERIOD_NS));

  // phase durations in seconds
  localparam logic [5:0] SPLASH_S = 6'h05;
  localparam logic [5:0] PREHEAT_S = 6'h0A;
  localparam logic [5:0] COLD_PREHEAT_S = 6'h28;
  localparam logic [5:0] OVERRIDE_S = 6'h0A;
  localparam logic [5:0] SEC_SAT = 6'h3F;

  // temperature limits in degrees celsius
  localparam logic signed [7:0] FREEZE_C = 8'sh00;
  localparam logic signed [7:0] INV_TRIP_C = 8'sh4B;

  // utilisation and service interval limits
  localparam logic [6:0] LOAD_FULL_PCT = 7'h64;
  localparam logic [23:0] SVC_EXT_PCT = 24'h00001E;
  localparam logic [23:0] PCT_DIV = 24'h000064;
  localparam logic [15:0] SVC_EXT_MAX_H = 16'h00C8;

  // reset values
  localparam logic [15:0] START_RPM_DEF = 16'h0190;
  localparam logic [2:0] INV_PAGES_DEF = 3'h1;

  // bit positions inside the synchronised input vector
  localparam int IN_ONOFF = 32'h0;
  localparam int IN_START = 32'h1;
  localparam int IN_UP = 32'h2;
  localparam int IN_DOWN = 32'h3;
  localparam int IN_CLUTCH = 32'h4;
  localparam int NUM_SYNC = 32'h5;

  // operating modes, also used as status text selector
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_STANDBY,
    MODE_PREHEAT,
    MODE_STARTING,
    MODE_START_FAIL,
    MODE_OVERRIDE,
    MODE_RUNNING,
    MODE_STOPPING
  } mode_t;

  // display screen selector
  typedef enum logic [2:0] {
    SCR_BLANK,
    SCR_SPLASH,
    SCR_DEFAULT,
    SCR_SERVICE,
    SCR_INVERTER
  } screen_t;

endpackage : genset_pkg

// File: verilog/genset_start_mode_sequencer.sv
`timescale 1ns/1ns
module genset_start_mode_sequencer #(
  parameter int SecCycles = genset_pkg::SEC_CYCLES,
  parameter logic [2:0] NumInvPages = genset_pkg::INV_PAGES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // panel buttons and clutch sense, raw pins, active high
  input wire logic btnOnOff,
  input wire logic btnStartStop,
  input wire logic btnUp,
  input wire logic btnDown,
  input wire logic clutchEngaged,
  // measurements from the same clock domain
  input wire logic signed [7:0] headTempC,
  input wire logic signed [7:0] inverterTempC,
  input wire logic [15:0] engineRpm,
  input wire logic [6:0] loadPct,
  input wire logic faultIn,
  // start configuration
  input wire logic [15:0] startRpm,
  input wire logic [5:0] crankLimitSec,
  // service interval accounting
  input wire logic dynamicHoursEn,
  input wire logic [15:0] serviceBaseH,
  input wire logic [15:0] serviceExtraH,
  // mode and display
  output genset_pkg::mode_t statusMode,
  output genset_pkg::screen_t screenSel,
  output logic [2:0] inverterPage,
  output logic [6:0] barPct,
  output logic [15:0] serviceIntervalH,
  output logic startFailed,
  output logic faultActive,
  // actuators
  output logic powerDown,
  output logic glowOn,
  output logic starterOn,
  output logic fuelRun,
  output logic inverterOn,
  output logic speedMax
);
  import genset_pkg::*;

  // smaller of two hour counts
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction : min16

  // whole state of the sequencer, outputs included
  typedef struct packed {
    mode_t mode;
    screen_t screen;
    logic [2:0] invPage;
    logic [5:0] phaseSec;
    logic [5:0] splashSec;
    logic coldStart;
    logic [6:0] bar;
    logic [15:0] svcHours;
    logic startFail;
    logic faultAct;
    logic powerDown;
    logic glow;
    logic starter;
    logic fuel;
    logic inverter;
    logic speedMax;
  } seq_state_t;

  // stand-by with the splash screen, every other field cleared
  localparam seq_state_t ST_RESET = '{mode: MODE_STANDBY, screen: SCR_SPLASH, default: '0};

  seq_state_t st_ff; // registered state
  seq_state_t nxt_st; // next state

  logic [NUM_SYNC-1:0] rawPins; // pins in sync order
  logic [NUM_SYNC-1:0] pinLevel; // synchronised levels
  logic [NUM_SYNC-1:0] pinPress; // one-cycle presses
  logic secTick; // one pulse per second
  logic phaseRestart; // mode change, realign the second
  logic [5:0] preheatLen; // selected pre-heat length
  logic [23:0] extPct; // 30 percent of base interval
  logic [15:0] extLimit; // extension ceiling in hours
  logic cursorPress; // either cursor button
  logic [16:0] svcSum; // base plus capped bonus, carry kept

  assign rawPins = {clutchEngaged, btnDown, btnUp, btnStartStop, btnOnOff};

  // pin synchroniser and edge detector
  button_sync #(
    .Width(NUM_SYNC)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .rawIn(rawPins),
    .level(pinLevel),
    .press(pinPress)
  );

  // second base, restarted on every mode change
  second_tick #(
    .Cycles(SecCycles)
  ) u_tick (
    .clk(clk),
    .resetn(resetn),
    .restart(phaseRestart),
    .tick(secTick)
  );

  // the prescaler restarts on a mode change, so each new phase counts its seconds from its first cycle
  assign phaseRestart = (nxt_st.mode != st_ff.mode);
  assign cursorPress = pinPress[IN_UP] | pinPress[IN_DOWN];
  assign preheatLen = st_ff.coldStart ? COLD_PREHEAT_S : PREHEAT_S;

  // extension ceiling: 30 percent of the base, never above 200 hours
  assign extPct = ({8'h00, serviceBaseH} * SVC_EXT_PCT) / PCT_DIV;
  assign extLimit = min16(extPct[15:0], SVC_EXT_MAX_H);
  assign svcSum = {1'b0, serviceBaseH} + {1'b0, min16(serviceExtraH, extLimit)};

  // mode sequencing and output decoding
  always_comb
  begin
    nxt_st = st_ff;
    // phase seconds, saturating so a long stop never wraps
    nxt_st.phaseSec = st_ff.phaseSec + {5'h00, (secTick && (st_ff.phaseSec != SEC_SAT))};
    // splash screen gives way after five seconds
    if (st_ff.screen == SCR_SPLASH && secTick)
    begin
      nxt_st.splashSec = st_ff.splashSec + 6'h01;
      if (st_ff.splashSec + 6'h01 >= SPLASH_S)
      begin
        nxt_st.screen = SCR_DEFAULT;
      end
    end
    case (st_ff.mode)
      // controller switched off, only on/off wakes it
      MODE_OFF:
      begin
        if (pinPress[IN_ONOFF])
        begin
          nxt_st.mode = MODE_STANDBY;
          nxt_st.screen = SCR_SPLASH;
          nxt_st.splashSec = 6'h00;
        end
      end
      // waiting for the operator
      MODE_STANDBY:
      begin
        if (pinPress[IN_ONOFF])
        begin
          nxt_st.mode = MODE_OFF;
          nxt_st.screen = SCR_BLANK;
        end
        else if (pinPress[IN_START])
        begin
          nxt_st.mode = MODE_PREHEAT;
          nxt_st.coldStart = (headTempC < FREEZE_C);
          nxt_st.screen = SCR_DEFAULT;
        end
        else if (cursorPress && st_ff.screen != SCR_SPLASH)
        begin
          // toggle between default and service view
          nxt_st.screen = (st_ff.screen == SCR_SERVICE) ? SCR_DEFAULT : SCR_SERVICE;
        end
      end
      // glow heater on for the pre-heat length chosen by coldStart
      MODE_PREHEAT:
      begin
        if (pinPress[IN_START])
        begin
          nxt_st.mode = MODE_STANDBY;
        end
        else if (st_ff.phaseSec >= preheatLen)
        begin
          nxt_st.mode = MODE_STARTING;
        end
      end
      // single crank, ended by speed, by the time limit or by a start press
      MODE_STARTING:
      begin
        if (engineRpm > startRpm)
        begin
          nxt_st.mode = MODE_OVERRIDE;
        end
        else if (pinPress[IN_START])
        begin
          nxt_st.mode = MODE_STANDBY;
        end
        else if (st_ff.phaseSec >= crankLimitSec)
        begin
          nxt_st.mode = MODE_START_FAIL;
        end
      end
      // failure shown until acknowledged, never a retry
      MODE_START_FAIL:
      begin
        if (cursorPress || pinPress[IN_START])
        begin
          nxt_st.mode = MODE_STANDBY;
        end
      end
      // warm-up window, faults are not looked at here
      MODE_OVERRIDE:
      begin
        if (pinPress[IN_START])
        begin
          nxt_st.mode = MODE_STOPPING;
        end
        else if (st_ff.phaseSec >= OVERRIDE_S)
        begin
          nxt_st.mode = MODE_RUNNING;
        end
      end
      // normal operation
      MODE_RUNNING:
      begin
        if (pinPress[IN_START] || faultIn)
        begin
          nxt_st.mode = MODE_STOPPING;
          nxt_st.screen = SCR_DEFAULT;
        end
        else if (pinPress[IN_UP])
        begin
          // walk default, inverter pages, back to default
          if (st_ff.screen != SCR_INVERTER)
          begin
            nxt_st.screen = SCR_INVERTER;
            nxt_st.invPage = 3'h0;
          end
          else if (st_ff.invPage + 3'h1 >= NumInvPages)
          begin
            nxt_st.screen = SCR_DEFAULT;
          end
          else
          begin
            nxt_st.invPage = st_ff.invPage + 3'h1;
          end
        end
        else if (pinPress[IN_DOWN])
        begin
          nxt_st.screen = SCR_DEFAULT;
        end
      end
      // fuel cut, wait for the engine to stand still
      MODE_STOPPING:
      begin
        if (engineRpm == 16'h0000)
        begin
          nxt_st.mode = MODE_STANDBY;
        end
      end
    endcase
    // a new phase counts from zero
    if (nxt_st.mode != st_ff.mode)
    begin
      nxt_st.phaseSec = 6'h00;
      if (st_ff.screen == SCR_SERVICE || st_ff.screen == SCR_INVERTER)
      begin
        nxt_st.screen = SCR_DEFAULT;
      end
    end
    // outputs decoded from the next mode so they change with it
    nxt_st.powerDown = (nxt_st.mode == MODE_OFF);
    nxt_st.glow = (nxt_st.mode == MODE_PREHEAT);
    nxt_st.starter = (nxt_st.mode == MODE_STARTING);
    nxt_st.fuel = (nxt_st.mode == MODE_STARTING) || (nxt_st.mode == MODE_OVERRIDE) ||
                  (nxt_st.mode == MODE_RUNNING);
    nxt_st.startFail = (nxt_st.mode == MODE_START_FAIL);
    // fault seen in running, held through the stop it causes, never in override
    nxt_st.faultAct = (faultIn && (st_ff.mode == MODE_RUNNING)) ||
                      (st_ff.faultAct && (nxt_st.mode == MODE_STOPPING));
    // inverter runs only with the board below the trip point
    nxt_st.inverter = ((nxt_st.mode == MODE_OVERRIDE) || (nxt_st.mode == MODE_RUNNING)) &&
                      (inverterTempC < INV_TRIP_C);
    // full speed while the clutch holds in override or running, normal speed otherwise
    nxt_st.speedMax = pinLevel[IN_CLUTCH] &&
                      ((nxt_st.mode == MODE_OVERRIDE) || (nxt_st.mode == MODE_RUNNING));
    // bar graph is a guide value, clipped at full scale, zero outside running
    nxt_st.bar = (nxt_st.mode != MODE_RUNNING) ? 7'h00 :
                 ((loadPct > LOAD_FULL_PCT) ? LOAD_FULL_PCT : loadPct);
    // service interval; a carry out clips the sum rather than wrapping it
    nxt_st.svcHours = !dynamicHoursEn ? serviceBaseH : (svcSum[16] ? 16'hFFFF : svcSum[15:0]);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= ST_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // every output straight from the state register
  assign statusMode = st_ff.mode;
  assign screenSel = st_ff.screen;
  assign inverterPage = st_ff.invPage;
  assign barPct = st_ff.bar;
  assign serviceIntervalH = st_ff.svcHours;
  assign startFailed = st_ff.startFail;
  assign faultActive = st_ff.faultAct;
  assign powerDown = st_ff.powerDown;
  assign glowOn = st_ff.glow;
  assign starterOn = st_ff.starter;
  assign fuelRun = st_ff.fuel;
  assign inverterOn = st_ff.inverter;
  assign speedMax = st_ff.speedMax;

endmodule : genset_start_mode_sequencer

// File: verilog/second_tick.sv
`timescale 1ns/1ns
module second_tick #(
  parameter int Cycles = genset_pkg::SEC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // restarts the second so a phase gets whole seconds
  input wire logic restart,
  // one-cycle pulse each second
  output logic tick
);
  import genset_pkg::*;

  localparam int CW = (Cycles > 2) ? $clog2(Cycles) : 1;
  localparam logic [CW-1:0] LAST = CW'(Cycles - 1);

  // whole state: prescaler and pulse
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t st_ff; // registered state
  tick_state_t nxt_st; // next state

  // prescaler, wraps after one second
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (restart)
    begin
      nxt_st.cnt = '0;
    end
    else if (st_ff.cnt == LAST)
    begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : second_tick
